/* File: hdl/sspp_pkg.sv */
// Purpose: Constants shared by both ends of the synthesizer serial programming port
// Assumes: 50 MHz system clock on both ends
// Notes:   How it works list below
//
// How it works
// - A transfer is exactly 24 bits: address, data
// - Address byte goes out MSB first
// - Data word follows, bit 15 first
// - Edge select 1 picks rising, 0 falling
// - Host stops serial clock once fully programmed
// - UHF frequency uses divider formula over 2M
// - S-band frequency uses same formula, no divide
// - At most one S-band oscillator enabled
// - UHF compares at half reference, S-band at reference
// - At 18 MHz steps are 1 MHz, 50/62.5 kHz
// - Step scales linearly with reference frequency
// - Addresses 0x80, 0x81, 0x84 decode; others reserved
// - Fraction 4:0, swallow 7:5, coarse above
// - Idle inputs rest high; enable is level sensitive
package sspp_pkg;
  localparam int          WORD_BITS      = 24;
  localparam int          ADDR_BITS      = 8;
  localparam int          DATA_BITS      = 16;
  localparam logic [7:0]  ADDR_UHF       = 8'h80;
  localparam logic [7:0]  ADDR_SBAND     = 8'h81;
  localparam logic [7:0]  ADDR_EDGE      = 8'h84;
  localparam int          FRAC_LSB       = 0;
  localparam int          FRAC_W         = 5;
  localparam int          SWAL_LSB       = 5;
  localparam int          SWAL_W         = 3;
  localparam int          COARSE_LSB     = 8;
  localparam int          COARSE_W       = 6;
  localparam int          EDGE_BIT       = 8;
  localparam int          FRAC_MAX       = 17;
  localparam int          FRAC_DEN       = 18;
  localparam int          COARSE_MUL     = 8;
  localparam int          COARSE_OFS     = 3;
  localparam int          M_LOW          = 10;
  localparam int          M_HIGH         = 8;
  localparam int          REF_FREQ_KHZ   = 18000;
  localparam int          SYS_PERIOD_NS  = 20;
  localparam int          LINK_PERIOD_NS = 160;
  localparam int          HALF_CYC       = (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;
  localparam logic        EDGE_RESET     = 1'b1;
  // Host register indexes
  localparam logic [1:0]  REG_WORD       = 2'h0;
  localparam logic [1:0]  REG_STATUS     = 2'h1;
  localparam logic [1:0]  REG_CTRL       = 2'h2;
endpackage : sspp_pkg

/* File: hdl/sspp_if.sv */
// Purpose: Three-wire serial programming link between host and synthesizer
// Assumes: Host drives all three wires
// Notes:   Unconnected wires must be pulled high by the bench
`timescale 1ns/100ps
interface sspp_if;
  logic ser_clk;
  logic ser_data;
  logic ser_en_n;
  modport dev  (input ser_clk, input ser_data, input ser_en_n);
  modport host (output ser_clk, output ser_data, output ser_en_n);
endinterface : sspp_if

/* File: hdl/sspp_dev.sv */
// Purpose: Synthesizer end: receives 24-bit words, holds counts, derives frequencies
// Assumes: Link wires are asynchronous to clk_sys and pass two flip-flops
// Notes:   Frequencies are reported in kHz, steps in Hz, compare rates in kHz
`timescale 1ns/100ps
module sspp_dev #(
  parameter int REF_KHZ   = sspp_pkg::REF_FREQ_KHZ,
  parameter bit HIGH_VAR  = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  sspp_if.dev              link,
  input  wire logic        sband_osc_pick,
  output logic [5:0]       uhf_coarse_q,
  output logic [2:0]       uhf_swallow_q,
  output logic [4:0]       uhf_fraction_q,
  output logic [5:0]       sband_coarse_q,
  output logic [2:0]       sband_swallow_q,
  output logic [4:0]       sband_fraction_q,
  output logic             ref_edge_select_q,
  output logic [2:0]       loaded_q,
  output logic             word_error_q,
  output logic             sband_osc_first_q,
  output logic             sband_osc_second_q,
  output logic [31:0]      uhf_local_osc_khz_q,
  output logic [31:0]      sband_local_osc_khz_q,
  output logic [31:0]      uhf_step_hz_q,
  output logic [31:0]      sband_step_hz_q,
  output logic [31:0]      uhf_compare_khz_q,
  output logic [31:0]      sband_compare_khz_q
);

  localparam int M_DIV = HIGH_VAR ? sspp_pkg::M_HIGH : sspp_pkg::M_LOW;

  initial
  begin
    if (REF_KHZ < 1 || REF_KHZ > 200000)
      $error("sspp_dev: REF_KHZ out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, idle high

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       clk_prev_q;
  logic       en_prev_q;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end
    else
    begin
      sync1_q <= {link.ser_en_n, link.ser_data, link.ser_clk};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clk_prev_q <= 1'b1;
      en_prev_q  <= 1'b1;
    end
    else
    begin
      clk_prev_q <= sync2_q[0];
      en_prev_q  <= sync2_q[2];
    end
  end

  logic sclk_rise;
  logic en_low;
  logic en_rise;
  assign sclk_rise = sync2_q[0] & ~clk_prev_q;
  assign en_low    = ~sync2_q[2];
  assign en_rise   = sync2_q[2] & ~en_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and bit count

  logic [23:0] shift_q;
  logic [4:0]  count_q;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      shift_q <= 24'h000000;
    else if (en_low && sclk_rise)
      shift_q <= {shift_q[22:0], sync2_q[1]};
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      count_q <= 5'h00;
    else if (!en_low)
      count_q <= 5'h00;
    else if (sclk_rise && count_q != 5'h1F)
      count_q <= count_q + 5'h01;
  end

  logic       word_ok;
  logic [7:0] w_addr;
  logic [15:0] w_data;
  assign word_ok = en_rise && count_q == 5'(sspp_pkg::WORD_BITS);
  assign w_addr  = shift_q[23:16];
  assign w_data  = shift_q[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Word apply

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      uhf_coarse_q     <= 6'h00;
      uhf_swallow_q    <= 3'h0;
      uhf_fraction_q   <= 5'h00;
      sband_coarse_q   <= 6'h00;
      sband_swallow_q  <= 3'h0;
      sband_fraction_q <= 5'h00;
      ref_edge_select_q <= sspp_pkg::EDGE_RESET;
      loaded_q         <= 3'h0;
    end
    else if (word_ok)
    begin
      if (w_addr == sspp_pkg::ADDR_UHF)
      begin
        uhf_coarse_q   <= w_data[sspp_pkg::COARSE_LSB +: sspp_pkg::COARSE_W];
        uhf_swallow_q  <= w_data[sspp_pkg::SWAL_LSB +: sspp_pkg::SWAL_W];
        uhf_fraction_q <= w_data[sspp_pkg::FRAC_LSB +: sspp_pkg::FRAC_W];
        loaded_q[0]    <= 1'b1;
      end
      else if (w_addr == sspp_pkg::ADDR_SBAND)
      begin
        sband_coarse_q   <= w_data[sspp_pkg::COARSE_LSB +: sspp_pkg::COARSE_W];
        sband_swallow_q  <= w_data[sspp_pkg::SWAL_LSB +: sspp_pkg::SWAL_W];
        sband_fraction_q <= w_data[sspp_pkg::FRAC_LSB +: sspp_pkg::FRAC_W];
        loaded_q[1]      <= 1'b1;
      end
      else if (w_addr == sspp_pkg::ADDR_EDGE)
      begin
        ref_edge_select_q <= w_data[sspp_pkg::EDGE_BIT];
        loaded_q[2]       <= 1'b1;
      end
    end
  end

  // Short, long, reserved-address or out-of-range fraction words are flagged
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      word_error_q <= 1'b0;
    else if (en_rise)
      word_error_q <= !word_ok
                      || !(w_addr == sspp_pkg::ADDR_UHF || w_addr == sspp_pkg::ADDR_SBAND
                           || w_addr == sspp_pkg::ADDR_EDGE)
                      || (w_addr != sspp_pkg::ADDR_EDGE
                          && w_data[4:0] > 5'(sspp_pkg::FRAC_MAX));
  end

  ////////////////////////////////////////////////////////////////////////////
  // S-band oscillator select, never both on

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sband_osc_first_q  <= 1'b0;
      sband_osc_second_q <= 1'b0;
    end
    else
    begin
      sband_osc_first_q  <= loaded_q[1] & ~sband_osc_pick;
      sband_osc_second_q <= loaded_q[1] &  sband_osc_pick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frequency, step and compare rate

  // Multiplier in eighteenths of the reference
  function automatic logic [31:0] mult18(input logic [5:0] n, input logic [2:0] s,
                                         input logic [4:0] f);
    logic [31:0] t;
    t = 32'(sspp_pkg::COARSE_MUL) * (32'(n) + 32'(sspp_pkg::COARSE_OFS)) - 32'(s);
    return 32'(sspp_pkg::FRAC_DEN) * t - 32'(f);
  endfunction : mult18

  logic [47:0] uhf_prod;
  logic [47:0] sband_prod;
  assign uhf_prod   = 48'(REF_KHZ) * 48'(mult18(uhf_coarse_q, uhf_swallow_q, uhf_fraction_q));
  assign sband_prod = 48'(REF_KHZ)
                      * 48'(mult18(sband_coarse_q, sband_swallow_q, sband_fraction_q));

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      uhf_local_osc_khz_q   <= 32'h00000000;
      sband_local_osc_khz_q <= 32'h00000000;
      uhf_step_hz_q         <= 32'h00000000;
      sband_step_hz_q       <= 32'h00000000;
      uhf_compare_khz_q     <= 32'h00000000;
      sband_compare_khz_q   <= 32'h00000000;
    end
    else
    begin
      uhf_local_osc_khz_q   <= 32'(uhf_prod / 48'(sspp_pkg::FRAC_DEN * 2 * M_DIV));
      sband_local_osc_khz_q <= 32'(sband_prod / 48'(sspp_pkg::FRAC_DEN));
      uhf_step_hz_q   <= 32'((REF_KHZ * 1000) / (sspp_pkg::FRAC_DEN * 2 * M_DIV));
      sband_step_hz_q <= 32'((REF_KHZ * 1000) / sspp_pkg::FRAC_DEN);
      uhf_compare_khz_q   <= 32'(REF_KHZ / 2);
      sband_compare_khz_q <= 32'(REF_KHZ);
    end
  end

endmodule : sspp_dev

/* File: hdl/sspp_host.sv */
// Purpose: Host end: sends 24-bit programming words ordered over a register port
// Assumes: Software writes one word at a time and polls busy
// Notes:   Serial clock rests high and stops between words
`timescale 1ns/100ps
module sspp_host #(
  parameter int HALF = sspp_pkg::HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  sspp_if.host             link,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_q
);

  initial
  begin
    if (HALF < 1 || HALF > 255)
      $error("sspp_host: HALF out of range");
  end

  typedef enum logic [1:0] {SSPP_IDLE, SSPP_LOW, SSPP_HIGH, SSPP_GAP} sspp_state_t;

  sspp_state_t state_q;
  logic [23:0] word_q;
  logic [4:0]  bits_q;
  logic [7:0]  tmr_q;
  logic [2:0]  sent_q;
  logic        clk_q;
  logic        data_q;
  logic        en_n_q;
  logic        tick;
  logic        start;

  assign tick  = tmr_q == 8'(HALF - 1);
  assign start = reg_wr && reg_addr == sspp_pkg::REG_WORD && state_q == SSPP_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= SSPP_IDLE;
      tmr_q   <= 8'h00;
      bits_q  <= 5'h00;
      word_q  <= 24'h000000;
      clk_q   <= 1'b1;
      data_q  <= 1'b1;
      en_n_q  <= 1'b1;
    end
    else
    begin
      tmr_q <= (state_q == SSPP_IDLE || tick) ? 8'h00 : tmr_q + 8'h01;
      case (state_q)
        SSPP_IDLE:
        begin
          if (start)
          begin
            word_q  <= {reg_wdata[22:0], 1'b0};
            data_q  <= reg_wdata[23];
            clk_q   <= 1'b0;
            en_n_q  <= 1'b0;
            bits_q  <= 5'h00;
            state_q <= SSPP_LOW;
          end
        end
        SSPP_LOW:
        begin
          if (tick)
          begin
            clk_q   <= 1'b1;
            bits_q  <= bits_q + 5'h01;
            state_q <= SSPP_HIGH;
          end
        end
        SSPP_HIGH:
        begin
          if (tick)
          begin
            if (bits_q == 5'(sspp_pkg::WORD_BITS))
            begin
              en_n_q  <= 1'b1;
              data_q  <= 1'b1;
              state_q <= SSPP_GAP;
            end
            else
            begin
              clk_q   <= 1'b0;
              data_q  <= word_q[23];
              word_q  <= {word_q[22:0], 1'b0};
              state_q <= SSPP_LOW;
            end
          end
        end
        SSPP_GAP:
        begin
          if (tick)
            state_q <= SSPP_IDLE;
        end
        default: state_q <= SSPP_IDLE;
      endcase
    end
  end

  assign link.ser_clk  = clk_q;
  assign link.ser_data = data_q;
  assign link.ser_en_n = en_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Programmed-word tracking

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      sent_q <= 3'h0;
    else if (reg_wr && reg_addr == sspp_pkg::REG_CTRL && reg_wdata[0])
      sent_q <= 3'h0;
    else if (start)
    begin
      if (reg_wdata[23:16] == sspp_pkg::ADDR_UHF)
        sent_q[0] <= 1'b1;
      else if (reg_wdata[23:16] == sspp_pkg::ADDR_SBAND)
        sent_q[1] <= 1'b1;
      else if (reg_wdata[23:16] == sspp_pkg::ADDR_EDGE)
        sent_q[2] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata_q <= 32'h00000000;
    else if (reg_rd && reg_addr == sspp_pkg::REG_STATUS)
      reg_rdata_q <= {27'h0000000, &sent_q, sent_q, state_q != SSPP_IDLE};
    else if (reg_rd && reg_addr == sspp_pkg::REG_WORD)
      reg_rdata_q <= {8'h00, word_q};
    else
      reg_rdata_q <= 32'h00000000;
  end

endmodule : sspp_host

/* File: verif/sspp_monitor.sv */
// Purpose: Protocol checks on the three-wire programming link
// Assumes: Host built with a half period of 4 system clocks
// Notes:   Sees only the link wires, the system clock and reset
`timescale 1ns/100ps
module sspp_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_en_n
);
  logic       clk_d_q;
  logic [5:0] rise_cnt_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      clk_d_q <= 1'b1;
    else
      clk_d_q <= ser_clk;
  end

  // Serial clock rises seen in the current frame
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rise_cnt_q <= 6'h00;
    else if (ser_en_n)
      rise_cnt_q <= 6'h00;
    else if (ser_clk && !clk_d_q && rise_cnt_q != 6'h3F)
      rise_cnt_q <= rise_cnt_q + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_word_length: assert property ($rose(ser_en_n) |-> rise_cnt_q == 6'h18)
    else $error("frame did not carry 24 clock rises");
  a_frame_span: assert property ($fell(ser_en_n) |-> ##[180:210] $rose(ser_en_n))
    else $error("frame length out of bounds");
  a_idle_levels: assert property (ser_en_n |-> ser_clk && ser_data)
    else $error("link wires not high outside a frame");
  a_frame_open: assert property ($fell(ser_en_n) |-> $fell(ser_clk))
    else $error("frame did not open with clock low");
  a_data_hold: assert property (!ser_en_n && ser_clk |-> $stable(ser_data))
    else $error("data moved while serial clock high");
  a_clk_high: assert property ($rose(ser_clk) |-> ser_clk [*4])
    else $error("serial clock high phase too short");
  a_clk_low: assert property ($fell(ser_clk) |-> !ser_clk [*4])
    else $error("serial clock low phase too short");
  a_frame_gap: assert property ($rose(ser_en_n) |-> ser_en_n [*4])
    else $error("enable gap between frames too short");
endmodule : sspp_monitor

/* File: verif/testbench.sv */
// Purpose: Host end sends words over the link to the synthesizer end
// Assumes: 50 MHz clock, host half period 4, 18 MHz reference, low variant
// Notes:   Link word is also captured from the wires and compared
`timescale 1ns/100ps
module testbench;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, pick;
  logic [1:0]  reg_addr;
  logic [31:0] reg_wdata, rdata, v, wword, wcnt, failures, compares, cyc;
  logic [5:0]  u_crs, s_crs;
  logic [2:0]  u_swl, s_swl, loaded;
  logic [4:0]  u_frc, s_frc;
  logic        edge_sel, werr, osc_a, osc_b;
  logic [31:0] u_f, s_f, u_st, s_st, u_cmp, s_cmp;

  sspp_if bus ();
  sspp_host #(.HALF(4)) i_sspp_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(bus),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(rdata));
  sspp_dev #(.REF_KHZ(sspp_pkg::REF_FREQ_KHZ), .HIGH_VAR(1'b0)) i_sspp_dev (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(bus), .sband_osc_pick(pick),
    .uhf_coarse_q(u_crs), .uhf_swallow_q(u_swl), .uhf_fraction_q(u_frc),
    .sband_coarse_q(s_crs), .sband_swallow_q(s_swl), .sband_fraction_q(s_frc),
    .ref_edge_select_q(edge_sel), .loaded_q(loaded), .word_error_q(werr),
    .sband_osc_first_q(osc_a), .sband_osc_second_q(osc_b),
    .uhf_local_osc_khz_q(u_f), .sband_local_osc_khz_q(s_f), .uhf_step_hz_q(u_st),
    .sband_step_hz_q(s_st), .uhf_compare_khz_q(u_cmp), .sband_compare_khz_q(s_cmp));
  sspp_monitor i_sspp_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst), .ser_clk(bus.ser_clk),
    .ser_data(bus.ser_data), .ser_en_n(bus.ser_en_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  function automatic logic [31:0] lo(input int n, input int s, input int f, input int dv);
    return 32'(sspp_pkg::REF_FREQ_KHZ * (18 * (8 * (n + 3) - s) - f) / (18 * dv));
  endfunction : lo

  // Sends one word, waits for the host, then checks what crossed the wires
  task automatic send(input logic [7:0] a, input logic [15:0] d);
    int i;
    wr(sspp_pkg::REG_WORD, {8'h00, a, d});
    for (i = 0; i < 400; i++)
    begin
      rd(sspp_pkg::REG_STATUS, v);
      if (v[0] === 1'b0)
        break;
    end
    if (i == 400)
      failures++;
    repeat (8) @(posedge clk_sys);
    check(wcnt, 32'h18);
    check({8'h00, wword[23:0]}, {8'h00, a, d});
  endtask : send

  always @(negedge bus.ser_en_n)
    wcnt = 0;
  always @(posedge bus.ser_clk)
    if (bus.ser_en_n === 1'b0)
    begin
      wword = {wword[22:0], bus.ser_data};
      wcnt++;
    end

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      complete_run();
    end
  end

  initial
  begin
    {sys_rst, reg_wr, reg_rd, pick, reg_addr, reg_wdata} = {4'h8, 2'h0, 32'h0};
    {failures, compares, cyc, wcnt, wword} = '0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    check({29'h0, bus.ser_clk, bus.ser_data, bus.ser_en_n}, 32'h7);
    check({28'h0, edge_sel, loaded}, 32'h8);
    rd(2'h3, v);
    check(v, 32'h0);
    send(sspp_pkg::ADDR_UHF, 16'h0569);
    check({18'h0, u_crs, u_swl, u_frc}, 32'h0569);
    check(u_f, lo(5, 3, 9, 2 * sspp_pkg::M_LOW));
    check(u_st, 32'h0000C350);
    check(u_cmp, 32'h00002328);
    send(sspp_pkg::ADDR_SBAND, 16'h1451);
    check({18'h0, s_crs, s_swl, s_frc}, 32'h1451);
    check(s_f, lo(20, 2, 17, 1));
    check(s_st, 32'h000F4240);
    check(s_cmp, 32'h00004650);
    check({29'h0, werr, osc_a, osc_b}, 32'h2);
    pick <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({30'h0, osc_a, osc_b}, 32'h1);
    send(sspp_pkg::ADDR_EDGE, 16'h0000);
    check({28'h0, edge_sel, loaded}, 32'h7);
    rd(sspp_pkg::REG_STATUS, v);
    check({27'h0, v[4:0]}, 32'h1E);
    send(sspp_pkg::ADDR_EDGE, 16'h0100);
    check({31'h0, edge_sel}, 32'h1);
    send(8'h82, 16'h1234);
    check({26'h0, werr, u_frc}, 32'h29);
    send(sspp_pkg::ADDR_UHF, 16'h0572);
    check({26'h0, werr, u_frc}, 32'h32);
    complete_run();
  end
endmodule : testbench
